// [src/acr_pkg.sv]
/*
 * Shared constants and types for the converter configuration register bank:
 * register addresses, reset values, register layouts, command codes,
 * serial phases and the bank's state record.
 * Assumes a single 50 MHz reference clock drives all logic.
 */
package acr_pkg;

    // Register addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MUX = 4'h1;
    localparam logic [3:0] ADDR_CONV = 4'h2;
    localparam logic [3:0] ADDR_RATE = 4'h3;
    localparam logic [3:0] ADDR_IO = 4'h4;
    localparam logic [3:0] ADDR_OTRIM0 = 4'h5;
    localparam logic [3:0] ADDR_OTRIM1 = 4'h6;
    localparam logic [3:0] ADDR_OTRIM2 = 4'h7;
    localparam logic [3:0] ADDR_GTRIM0 = 4'h8;
    localparam logic [3:0] ADDR_GTRIM1 = 4'h9;
    localparam logic [3:0] ADDR_GTRIM2 = 4'hA;
    localparam logic [3:0] ADDR_LAST = 4'hA;

    // Reset values
    localparam logic [2:0] RST_OPTS = 3'h0;
    localparam logic [7:0] RST_MUX = 8'h01;
    localparam logic [7:0] RST_CONV = 8'h20;
    localparam logic [7:0] RST_RATE = 8'hF0;
    localparam logic [7:0] RST_IO = 8'hE0;
    localparam logic [23:0] RST_TRIM = 24'h000000;

    // Command opcodes (upper nibble of first byte)
    localparam logic [3:0] CMD_REG_READ = 4'h1;
    localparam logic [3:0] CMD_REG_WRITE = 4'h5;

    // Clock-output divider codes
    localparam logic [1:0] CLKO_OFF = 2'h0;
    localparam logic [1:0] CLKO_DIV1 = 2'h1;
    localparam logic [1:0] CLKO_DIV2 = 2'h2;
    localparam logic [1:0] CLKO_DIV4 = 2'h3;

    // Highest distinct gain code
    localparam logic [2:0] GAIN_CODE_MAX = 3'h6;

    // Defined output-rate codes, fastest first
    localparam logic [7:0] RATE_CODES [16] = '{
        8'hF0, 8'hE0, 8'hD0, 8'hC0, 8'hB0, 8'hA1, 8'h92, 8'h82,
        8'h72, 8'h63, 8'h53, 8'h43, 8'h33, 8'h23, 8'h13, 8'h03
    };

    // Register layouts
    typedef struct packed {
        logic [3:0] part_code;
        logic order;
        logic auto_calibrate_enable;
        logic buf_on;
        logic ready;
    } acr_status_t;

    typedef struct packed {
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
    } acr_mux_t;

    typedef struct packed {
        logic rsv;
        logic [1:0] clk_div;
        logic [1:0] sensor;
        logic [2:0] gain;
    } acr_conv_t;

    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] lvl;
    } acr_io_t;

    // Decoded configuration handed to the converter core
    typedef struct packed {
        logic order;
        logic auto_calibrate_enable;
        logic buf_on;
        logic [3:0] pos_sel;
        logic pos_common;
        logic [3:0] neg_sel;
        logic neg_common;
        logic [1:0] clk_div;
        logic [1:0] sensor;
        logic [2:0] gain;
        logic [2:0] gain_shift;
        logic [7:0] rate_code;
        logic rate_defined;
    } acr_cfg_t;

    // Serial command phases
    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_COUNT = 2'b01,
        PH_WDATA = 2'b10,
        PH_RDATA = 2'b11
    } acr_phase_t;

    // Complete state of the bank
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic din_s1;
        logic din_s2;
        logic cs_n_s1;
        logic cs_n_s2;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        acr_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] rx_byte;
        logic is_read;
        logic [3:0] addr;
        logic [3:0] remain;
        logic [7:0] tx_byte;
        logic dout;
        logic dout_oe_n;
        logic [2:0] opts;
        acr_mux_t input_channel_select;
        acr_conv_t conv;
        logic [7:0] rate;
        acr_io_t io;
        logic [23:0] otrim;
        logic [23:0] gtrim;
        logic [2:0] snap_gain;
        logic [7:0] snap_rate;
        logic snap_buf;
        logic selfcal;
        logic other_valid;
        logic [7:0] other_code;
        logic [2:0] clk_cnt;
        logic [3:0] pin_out;
    } acr_state_t;

endpackage : acr_pkg

// [src/acr_reg_bank.sv]
/*
 * Configuration and status register bank of a 24-bit delta-sigma converter,
 * reached by the host over the serial port (clock, data in, data out,
 * chip select) with register read and write commands.
 * Assumes serial pins are asynchronous and slow against the 50 MHz
 * reference clock (at least four reference cycles per serial half period);
 * the converter core supplies the ready level, trim results and soft reset.
 */
//
// Contract
// - Output bytes MSB-byte first, bit order selectable; the code sends the trim registers low byte first
// - Input always MSB byte and bit first; the code writes the trim registers low byte first
// - Auto-calibrate after writes changing gain/rate/buffer
// - Buffer enable bit, reset off
// - Status bit 0 mirrors ready pin
// - Upper status nibble is read-only part code
// - Positive select: inputs 0-7, common if bit3
// - Negative select same encoding, resets to 0001
// - Converter control top bit reads zero
// - Clock output off, full, half, quarter; the code gives half, quarter and eighth of the reference clock
// - Clock field reset only by hardware pin
// - Sensor current off, 0.5, 2, 10 uA
// - Gain codes 1..64, code 7 also 64
// - Sixteen rate codes, default fastest
// - Rates scale with master clock frequency
// - Direction bit 0 output, 1 input
// - Level bits read actual pin state
// - Level write drives outputs only
// - Pin zero carries clock output when enabled; the code drives the clock there only while direction bit 0 selects output
// - Small variant keeps upper pin bits as storage
// - Read command: 0001 addr, then count-1
// - Write command: 0101 addr, count-1, data
// - Read past last register wraps to first
`timescale 1ns/1ps

module acr_reg_bank #(
    parameter logic [3:0] PART_CODE = 4'h3,
    parameter int NUM_PINS = 4
) (
    // Clock and resets
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_soft_reset,
    // Serial port
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_cs_n,
    output logic o_dout,
    output logic o_dout_oe_n,
    // Converter core status
    input wire logic i_conversion_ready_flag_n,
    // General-purpose pins
    input wire logic [3:0] i_pin_level,
    output logic [3:0] o_pin_level,
    output logic [3:0] o_pin_oe_n,
    // Calibration results
    input wire logic i_trim_load,
    input wire logic [23:0] i_offset_trim,
    input wire logic [23:0] i_gain_trim,
    // Configuration to converter core
    output acr_pkg::acr_cfg_t o_cfg,
    output logic [23:0] o_offset_trim,
    output logic [23:0] o_gain_trim,
    output logic o_selfcal_start,
    output logic o_other_cmd_valid,
    output logic [7:0] o_other_cmd
);
    import acr_pkg::*;

    acr_state_t state_reg;
    acr_state_t state_next;

    // Power-on values of every field
    function automatic acr_state_t reset_state();
        acr_state_t s;
        s = '0;
        s.cs_n_s1 = 1'b1;
        s.cs_n_s2 = 1'b1;
        s.phase = PH_CMD;
        s.dout_oe_n = 1'b1;
        s.opts = RST_OPTS;
        s.input_channel_select = acr_mux_t'(RST_MUX);
        s.conv = acr_conv_t'(RST_CONV);
        s.rate = RST_RATE;
        s.io = acr_io_t'(RST_IO);
        s.otrim = RST_TRIM;
        s.gtrim = RST_TRIM;
        return s;
    endfunction : reset_state

    // Address step with wrap past the last register
    function automatic logic [3:0] next_addr(input logic [3:0] a);
        return (a >= ADDR_LAST) ? 4'h0 : a + 4'h1;
    endfunction : next_addr

    // Actual pin levels, stored bits for absent pins
    function automatic logic [3:0] pin_view(input acr_state_t s);
        logic [3:0] v;
        v = s.io.lvl;
        for (int i = 0; i < 4; i++)
        begin
            if (i < NUM_PINS)
            begin
                v[i] = s.pin_s2[i];
            end
        end
        return v;
    endfunction : pin_view

    // Register read mux
    function automatic logic [7:0] read_reg(input acr_state_t s, input logic [3:0] a,
                                            input logic rdy);
        acr_status_t st;
        acr_conv_t ad;
        logic [7:0] d;
        st.part_code = PART_CODE;
        st.order = s.opts[2];
        st.auto_calibrate_enable = s.opts[1];
        st.buf_on = s.opts[0];
        st.ready = rdy;
        ad = s.conv;
        ad.rsv = 1'b0;
        case (a)
            ADDR_STATUS: d = st;
            ADDR_MUX: d = s.input_channel_select;
            ADDR_CONV: d = ad;
            ADDR_RATE: d = s.rate;
            ADDR_IO: d = {s.io.dir, pin_view(s)};
            ADDR_OTRIM0: d = s.otrim[7:0];
            ADDR_OTRIM1: d = s.otrim[15:8];
            ADDR_OTRIM2: d = s.otrim[23:16];
            ADDR_GTRIM0: d = s.gtrim[7:0];
            ADDR_GTRIM1: d = s.gtrim[15:8];
            ADDR_GTRIM2: d = s.gtrim[23:16];
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_reg

    // Membership in the defined rate table
    function automatic logic rate_defined(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            if (RATE_CODES[i] == code)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : rate_defined

    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] byte_in;
    logic clk_on;
    logic clk_wave;
    logic [3:0] new_dir;

    always_comb
    begin
        state_next = state_reg;
        sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_s3;
        sclk_fall = ~state_reg.sclk_s2 & state_reg.sclk_s3;
        byte_in = {state_reg.rx_byte[6:0], state_reg.din_s2};
        clk_on = (state_reg.conv.clk_div != CLKO_OFF);
        new_dir = '0;

        // Pin synchronisers
        state_next.sclk_s1 = i_sclk;
        state_next.sclk_s2 = state_reg.sclk_s1;
        state_next.sclk_s3 = state_reg.sclk_s2;
        state_next.din_s1 = i_din;
        state_next.din_s2 = state_reg.din_s1;
        state_next.cs_n_s1 = i_cs_n;
        state_next.cs_n_s2 = state_reg.cs_n_s1;
        state_next.pin_s1 = i_pin_level;
        state_next.pin_s2 = state_reg.pin_s1;

        state_next.selfcal = 1'b0;
        state_next.other_valid = 1'b0;
        state_next.clk_cnt = state_reg.clk_cnt + 3'h1;

        // Trim results from the calibration engine
        if (i_trim_load)
        begin
            state_next.otrim = i_offset_trim;
            state_next.gtrim = i_gain_trim;
        end

        if (state_reg.cs_n_s2)
        begin
            state_next.phase = PH_CMD;
            state_next.bit_cnt = 3'h0;
        end
        else
        begin
            // Output bit on rising serial clock
            if (sclk_rise && state_reg.phase == PH_RDATA)
            begin
                if (state_reg.opts[2])
                begin
                    state_next.dout = state_reg.tx_byte[state_reg.bit_cnt];
                end
                else
                begin
                    state_next.dout = state_reg.tx_byte[3'h7 - state_reg.bit_cnt];
                end
            end
            // Input bit on falling serial clock
            if (sclk_fall)
            begin
                state_next.rx_byte = byte_in;
                state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
                if (state_reg.bit_cnt == 3'h7)
                begin
                    case (state_reg.phase)
                        PH_CMD:
                        begin
                            if (byte_in[7:4] == CMD_REG_READ || byte_in[7:4] == CMD_REG_WRITE)
                            begin
                                state_next.is_read = (byte_in[7:4] == CMD_REG_READ);
                                state_next.addr = byte_in[3:0];
                                state_next.phase = PH_COUNT;
                            end
                            else
                            begin
                                state_next.other_valid = 1'b1;
                                state_next.other_code = byte_in;
                            end
                        end
                        PH_COUNT:
                        begin
                            state_next.remain = byte_in[3:0];
                            state_next.snap_gain = state_reg.conv.gain;
                            state_next.snap_rate = state_reg.rate;
                            state_next.snap_buf = state_reg.opts[0];
                            if (state_reg.is_read)
                            begin
                                state_next.tx_byte = read_reg(state_reg, state_reg.addr,
                                                              i_conversion_ready_flag_n);
                                state_next.phase = PH_RDATA;
                            end
                            else
                            begin
                                state_next.phase = PH_WDATA;
                            end
                        end
                        PH_WDATA:
                        begin
                            case (state_reg.addr)
                                ADDR_STATUS: state_next.opts = byte_in[3:1];
                                ADDR_MUX: state_next.input_channel_select = acr_mux_t'(byte_in);
                                ADDR_CONV:
                                begin
                                    state_next.conv = acr_conv_t'(byte_in);
                                    state_next.conv.rsv = 1'b0;
                                end
                                ADDR_RATE: state_next.rate = byte_in;
                                ADDR_IO:
                                begin
                                    new_dir = byte_in[7:4];
                                    state_next.io.dir = new_dir;
                                    for (int i = 0; i < 4; i++)
                                    begin
                                        if (i >= NUM_PINS)
                                        begin
                                            state_next.io.lvl[i] = byte_in[i];
                                        end
                                        else if (!new_dir[i] && !(i == 0 && clk_on))
                                        begin
                                            state_next.io.lvl[i] = byte_in[i];
                                        end
                                    end
                                end
                                ADDR_OTRIM0: state_next.otrim[7:0] = byte_in;
                                ADDR_OTRIM1: state_next.otrim[15:8] = byte_in;
                                ADDR_OTRIM2: state_next.otrim[23:16] = byte_in;
                                ADDR_GTRIM0: state_next.gtrim[7:0] = byte_in;
                                ADDR_GTRIM1: state_next.gtrim[15:8] = byte_in;
                                ADDR_GTRIM2: state_next.gtrim[23:16] = byte_in;
                                default: state_next.addr = state_reg.addr;
                            endcase
                            state_next.addr = next_addr(state_reg.addr);
                            if (state_reg.remain == 4'h0)
                            begin
                                state_next.phase = PH_CMD;
                                state_next.selfcal = state_next.opts[1] &&
                                    (state_next.conv.gain != state_reg.snap_gain ||
                                     state_next.rate != state_reg.snap_rate ||
                                     state_next.opts[0] != state_reg.snap_buf);
                            end
                            else
                            begin
                                state_next.remain = state_reg.remain - 4'h1;
                            end
                        end
                        PH_RDATA:
                        begin
                            state_next.addr = next_addr(state_reg.addr);
                            if (state_reg.remain == 4'h0)
                            begin
                                state_next.phase = PH_CMD;
                            end
                            else
                            begin
                                state_next.remain = state_reg.remain - 4'h1;
                                state_next.tx_byte = read_reg(state_reg,
                                                              next_addr(state_reg.addr),
                                                              i_conversion_ready_flag_n);
                            end
                        end
                        default: state_next.phase = PH_CMD;
                    endcase
                end
            end
        end
        state_next.dout_oe_n = (state_next.phase != PH_RDATA);

        // Clock output waveform
        case (state_reg.conv.clk_div)
            CLKO_DIV1: clk_wave = state_reg.clk_cnt[0];
            CLKO_DIV2: clk_wave = state_reg.clk_cnt[1];
            CLKO_DIV4: clk_wave = state_reg.clk_cnt[2];
            default: clk_wave = 1'b0;
        endcase
        state_next.pin_out = state_reg.io.lvl;
        if (clk_on && !state_reg.io.dir[0])
        begin
            state_next.pin_out[0] = clk_wave;
        end

        // Command or pattern reset keeps the clock field
        if (i_soft_reset)
        begin
            state_next = reset_state();
            state_next.conv.clk_div = state_reg.conv.clk_div;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            state_reg <= reset_state();
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Pin drivers
    always_comb
    begin
        o_pin_level = state_reg.pin_out;
        for (int i = 0; i < 4; i++)
        begin
            o_pin_oe_n[i] = (i < NUM_PINS) ? state_reg.io.dir[i] : 1'b1;
        end
    end

    // Decoded configuration
    always_comb
    begin
        o_cfg.order = state_reg.opts[2];
        o_cfg.auto_calibrate_enable = state_reg.opts[1];
        o_cfg.buf_on = state_reg.opts[0];
        o_cfg.pos_sel = state_reg.input_channel_select.pos_sel;
        o_cfg.pos_common = state_reg.input_channel_select.pos_sel[3];
        o_cfg.neg_sel = state_reg.input_channel_select.neg_sel;
        o_cfg.neg_common = state_reg.input_channel_select.neg_sel[3];
        o_cfg.clk_div = state_reg.conv.clk_div;
        o_cfg.sensor = state_reg.conv.sensor;
        o_cfg.gain = state_reg.conv.gain;
        o_cfg.gain_shift = (state_reg.conv.gain > GAIN_CODE_MAX) ?
                           GAIN_CODE_MAX : state_reg.conv.gain;
        o_cfg.rate_code = state_reg.rate;
        o_cfg.rate_defined = rate_defined(state_reg.rate);
    end

    assign o_dout = state_reg.dout;
    assign o_dout_oe_n = state_reg.dout_oe_n;
    assign o_offset_trim = state_reg.otrim;
    assign o_gain_trim = state_reg.gtrim;
    assign o_selfcal_start = state_reg.selfcal;
    assign o_other_cmd_valid = state_reg.other_valid;
    assign o_other_cmd = state_reg.other_code;

endmodule : acr_reg_bank

// [dv/acr_host_model.sv]
/* Serial host model: clocks bytes in and out of the register bank.
   Assumes the bench reference clock; half periods of 6 cycles. */
`timescale 1ns/1ps
module acr_host_model (
    // Clock
    input wire logic i_ref_clk,
    // Serial port
    input wire logic i_dout,
    output logic o_sclk,
    output logic o_din,
    output logic o_cs_n
);
    initial
    begin
        o_sclk = 1'b0;
        o_din = 1'b0;
        o_cs_n = 1'b1;
    end

    // One byte each way, MSB first; register and other command bytes, never continuous read
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge i_ref_clk);
            o_sclk <= 1'b1;
            o_din <= tx[i];
            repeat (6) @(posedge i_ref_clk);
            rx[i] = i_dout;
            o_sclk <= 1'b0;
            repeat (5) @(posedge i_ref_clk);
        end
    endtask : xfer

    // Select or release the device
    task automatic frame(input logic on);
        repeat (8) @(posedge i_ref_clk);
        o_cs_n <= !on;
        repeat (8) @(posedge i_ref_clk);
    endtask : frame
endmodule : acr_host_model

// [dv/acr_reg_bank_asserts.sv]
/* Port assertions for the register bank.
   Bound to every acr_reg_bank instance. */
`timescale 1ns/1ps
module acr_reg_bank_chk (
    // Clock and resets
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_soft_reset,
    // Watched ports
    input wire logic i_cs_n,
    input wire logic i_trim_load,
    input wire logic [23:0] i_offset_trim,
    input wire logic o_dout_oe_n,
    input wire logic [3:0] o_pin_oe_n,
    input wire acr_pkg::acr_cfg_t o_cfg,
    input wire logic [23:0] o_offset_trim,
    input wire logic o_selfcal_start,
    input wire logic o_other_cmd_valid
);
    import acr_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    a_reset_vals: assert property ($fell(i_reset) |-> o_dout_oe_n
        && o_pin_oe_n == 4'hE && o_cfg.gain == 3'h0 && o_cfg.rate_code == 8'hF0)
        else $error("outputs not at reset values");
    a_gain_map: assert property (o_cfg.gain_shift ==
        ((o_cfg.gain == 3'h7) ? 3'h6 : o_cfg.gain)) else $error("gain decode wrong");
    a_pos_common: assert property (o_cfg.pos_common == o_cfg.pos_sel[3])
        else $error("positive common flag wrong");
    a_neg_common: assert property (o_cfg.neg_common == o_cfg.neg_sel[3])
        else $error("negative common flag wrong");
    a_clk_keep: assert property (i_soft_reset |=> $stable(o_cfg.clk_div))
        else $error("soft reset changed clock field");
    a_cal_pulse: assert property (o_selfcal_start |->
        o_cfg.auto_calibrate_enable ##1 !o_selfcal_start) else $error("selfcal pulse wrong");
    a_oe_idle: assert property (i_cs_n [*5] |-> o_dout_oe_n)
        else $error("dout driven while deselected");
    a_trim_load: assert property (i_trim_load && i_cs_n && !i_soft_reset
        |=> o_offset_trim == $past(i_offset_trim)) else $error("trim load lost");
    a_other_pulse: assert property (o_other_cmd_valid |=> !o_other_cmd_valid)
        else $error("other command pulse too long");

    c_cal: cover property (o_selfcal_start);
    c_other: cover property (o_other_cmd_valid);
    c_read: cover property (!o_dout_oe_n);
endmodule : acr_reg_bank_chk

bind acr_reg_bank acr_reg_bank_chk u_chk (.*);

// [dv/acr_reg_bank_tb.sv]
/* Self-checking bench for the register bank.
   Assumes the host model drives the serial port. */
`timescale 1ns/1ps
module acr_reg_bank_tb;
    import acr_pkg::*;
    logic clk = 1'b0;
    logic rst;
    logic srst;
    logic rdy_n;
    logic ld;
    logic [23:0] gt;
    logic [3:0] ext;
    logic p0;
    logic sclk, din, cs_n, dout, oe_n, cal, oth;
    logic [3:0] pad, plvl, poe_n;
    acr_cfg_t cfg;
    logic [23:0] otrim, gtrim;
    logic [7:0] ocmd, rx;
    logic [7:0] q[$];
    logic [7:0] ex[$];
    int n_fail = 0;
    int num_checks = 0;
    int n_cal = 0;
    int n_oth = 0;
    int n_tog;

    always #10 clk = ~clk;
    always @(posedge clk) n_cal += cal;
    always @(posedge clk) n_oth += oth;
    // Pad level from driven and outside values
    assign pad = (poe_n & ext) | (~poe_n & plvl);

    // Released data line shows the inverse of the last bit
    acr_host_model u_host (.i_ref_clk(clk), .i_dout(oe_n ? ~dout : dout), .o_sclk(sclk),
        .o_din(din), .o_cs_n(cs_n));
    acr_reg_bank u_dut (.i_ref_clk(clk), .i_reset(rst), .i_soft_reset(srst),
        .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n), .o_dout(dout), .o_dout_oe_n(oe_n),
        .i_conversion_ready_flag_n(rdy_n), .i_pin_level(pad), .o_pin_level(plvl),
        .o_pin_oe_n(poe_n), .i_trim_load(ld), .i_offset_trim(~gt), .i_gain_trim(gt),
        .o_cfg(cfg), .o_offset_trim(otrim), .o_gain_trim(gtrim), .o_selfcal_start(cal),
        .o_other_cmd_valid(oth), .o_other_cmd(ocmd));

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic register_write_command(input logic [3:0] a);
        u_host.frame(1'b1);
        u_host.xfer({CMD_REG_WRITE, a}, rx);
        u_host.xfer(8'(q.size() - 1), rx);
        foreach (q[i]) u_host.xfer(q[i], rx);
        u_host.frame(1'b0);
    endtask : register_write_command

    task automatic register_read_command(input logic [3:0] a);
        u_host.frame(1'b1);
        u_host.xfer({CMD_REG_READ, a}, rx);
        u_host.xfer(8'(ex.size() - 1), rx);
        foreach (ex[i])
        begin
            u_host.xfer(8'h00, rx);
            chk(((a + i) % 11 == 4) ? rx & 8'hFE : rx, ex[i]);
        end
        u_host.frame(1'b0);
    endtask : register_read_command

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        rst <= 1'b1;
        srst <= 1'b0;
        rdy_n <= 1'b1;
        ld <= 1'b0;
        gt <= 24'h0;
        ext <= 4'hA;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        ex = '{8'h00, 8'h00, 8'h31, 8'h01, 8'h20, 8'hF0, 8'hEA, 0, 0, 0, 0, 0};
        register_read_command(4'h9);
        q = '{8'hF6, 8'h8F, 8'hFB, 8'h03, 8'h0F};
        register_write_command(4'h0);
        rdy_n <= 1'b0;
        chk(n_cal, 1);
        chk(poe_n, 4'h0);
        chk(plvl[3:1], 3'h7);
        ex = '{8'h36, 8'h8F, 8'h7B, 8'h03, 8'h0E};
        register_read_command(4'h0);
        q = '{8'h0E};
        register_write_command(4'h0);
        ex = '{8'hF1};
        register_read_command(4'h1);
        chk(n_cal, 1);
        srst <= 1'b1;
        ext <= 4'h4;
        @(posedge clk);
        srst <= 1'b0;
        ex = '{8'h60, 8'hF0, 8'hE4};
        register_read_command(4'h2);
        p0 = plvl[0];
        n_tog = 0;
        repeat (16)
        begin
            @(posedge clk);
            n_tog += (plvl[0] != p0);
            p0 = plvl[0];
        end
        chk(n_tog, 4);
        q = '{8'h11, 8'h22, 8'h33};
        register_write_command(4'h5);
        chk(otrim, 24'h332211);
        gt <= 24'hABCDEF;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        ex = '{8'hEF, 8'hCD, 8'hAB, 8'h30};
        register_read_command(4'h8);
        chk(otrim, 24'h543210);
        chk(gtrim, 24'hABCDEF);
        ex = '{8'h00};
        register_read_command(4'hB);
        u_host.frame(1'b1);
        u_host.xfer(8'hF0, rx);
        u_host.frame(1'b0);
        chk(ocmd, 8'hF0);
        chk(n_oth, 1);
        foreach (RATE_CODES[i])
        begin
            q = '{{5'h0C, 3'(i)}, RATE_CODES[i]};
            register_write_command(4'h2);
            chk({cfg.rate_defined, cfg.gain_shift, cfg.rate_code},
                {1'b1, (i % 8 == 7) ? 3'h6 : 3'(i), RATE_CODES[i]});
        end
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        ex = '{8'h20};
        register_read_command(4'h2);
        report_and_stop();
    end
endmodule : acr_reg_bank_tb
